// File: logic/uibm_defines.vh
// register offsets, field positions and timing counts for the bank/mode/status block
// assumes a 25 MHz clock and an 8-bit register window
`ifndef UIBM_DEFINES_VH
`define UIBM_DEFINES_VH
`define UIBM_OFS_BANK_SEL   4'h3
`define UIBM_OFS_MODE_CTL   4'h4
`define UIBM_OFS_LINK_STAT  4'h5
`define UIBM_OFS_LINK_CTL   4'h6
`define UIBM_OFS_EXT_CTL1   4'h7
`define UIBM_OFS_FIFO_CTL   4'h8
`define UIBM_OFS_CFG        4'h9
`define UIBM_BIT_BANK_WINDOW_ENABLE       7
`define UIBM_BIT_IRQ_GATE   3
`define UIBM_BIT_LOOP       4
`define UIBM_BIT_DMA_EN     2
`define UIBM_BIT_TRANSMIT_DEFERRAL     3
`define UIBM_BIT_IPULSE     4
`define UIBM_MODE_UART      3'h0
`define UIBM_MODE_ASK       3'h2
`define UIBM_MODE_SIR       3'h3
`define UIBM_MODE_MIR       3'h4
`define UIBM_MODE_FIR       3'h5
`define UIBM_MODE_CREM      3'h6
`define UIBM_RST_MODE_CTL   8'h00
`define UIBM_RST_BANK_SEL   8'h00
`define UIBM_CLK_MHZ        25
`define UIBM_PULSE_NS       2000
`define UIBM_PULSE_CYC      ((`UIBM_PULSE_NS * `UIBM_CLK_MHZ) / 1000)
`endif

// File: logic/uibm_top.v
// bank select, mode control and link status logic of a uart/ir controller
// assumes receiver/transmitter datapaths report events as one-cycle pulses on clock_i
`include "uibm_defines.vh"

// Notes on behaviour
// - window enable low selects bank zero
// - decode bank selector pattern into banks 0-7
// - link control image reads enable bit zero
// - mode control clears on reset, layout varies
// - extended mode keeps interrupt output enabled
// - basic mode gates interrupt with bit three
// - loop bit shared with extended control one
// - dma enable; dma reaches data regardless bank
// - transmit deferral only with transmit fifo
// - interaction pulse: set-only, 2us, self-clears
// - mode field; change soft-resets both directions
// - status bits 1-4 (7 in frame modes) sticky, clear on read
// - data available while receive data held
// - overrun on completion into full storage
// - parity fault set at fifo bottom
// - crc mismatch flagged in frame modes
// - framing fault and resync start bit
// - physical layer fault in frame modes
// - break detected, single zero character
// - oversize frame flagged in frame modes
// - holding free while transmit storage empty
// - fully empty needs idle front end
// - bit seven: errored char or frame end
module uibm_top (
  // clock and reset
  input  wire       clock_i,
  input  wire       rst_b_i,
  // register port
  input  wire [3:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  // receive side status from datapath
  input  wire       rx_char_done_i,
  input  wire       rx_store_full_i,
  input  wire       status_queue_full_i,
  input  wire       rx_nonempty_i,
  input  wire       rx_bottom_i,
  input  wire       rx_bottom_parity_i,
  input  wire       rx_bottom_framing_i,
  input  wire       rx_bottom_break_i,
  input  wire       rx_bottom_crc_i,
  input  wire       rx_bottom_phy_i,
  input  wire       rx_bottom_oversize_i,
  input  wire       rx_bottom_frame_end_i,
  input  wire       rx_err_in_fifo_i,
  // transmit side status from datapath
  input  wire       tx_store_empty_i,
  input  wire       tx_front_idle_i,
  input  wire       tx_frame_end_i,
  // controls to datapath
  output reg  [2:0] bank_o,
  output reg        bank_reserved_o,
  output wire       extended_mode_o,
  output wire [2:0] operating_mode_field_o,
  output wire       loopback_o,
  output wire       irq_enable_o,
  output wire       dma_enable_o,
  output wire       dma_data_route_o,
  output wire       transmit_deferral_o,
  output wire       fifo_enable_o,
  output reg        rx_soft_reset_o,
  output reg        tx_soft_reset_o,
  output reg        ir_pulse_o,
  output wire       tx_data_write_o,
  output wire       rx_data_read_o
);
  parameter PULSE_CYC = `UIBM_PULSE_CYC;

  reg        rst_s1;
  reg        rst_s2;
  reg  [7:0] bank_selector;
  reg  [6:0] link_control;
  reg        irq_output_gate;
  reg        loop_bit;
  reg        dma_en;
  reg        transmit_deferral;
  reg        interaction_pulse_request;
  reg  [2:0] mode_field;
  reg        ext_sel;
  reg        fifo_en;
  reg  [4:0] sticky;
  reg        frame_end_reached;
  reg  [7:0] pulse_cnt;
  reg        tx_written;
  wire       frame_mode;
  wire       status_read;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  assign frame_mode = ext_sel && (mode_field == `UIBM_MODE_MIR ||
                                  mode_field == `UIBM_MODE_FIR);

  // banks: 0 mode/status/tx data; bank select, ext1, fifo and cfg offsets act in every bank
  always @* begin
    bank_reserved_o = 1'b0;
    if (!bank_selector[`UIBM_BIT_BANK_WINDOW_ENABLE])
      bank_o = 3'h0;
    else if (!bank_selector[6] || bank_selector[1] || bank_selector[0])
      bank_o = 3'h1;
    else if (bank_selector[5] && !(bank_selector[4] && bank_selector[3]))
      bank_o = {bank_selector[4:3], bank_selector[2]} + 3'h2;
    else begin
      bank_o = 3'h0;
      bank_reserved_o = 1'b1;
    end
  end

  wire in_bank0 = (bank_o == 3'h0) && !bank_reserved_o;
  wire wr_bank  = wr_i && (addr_i == `UIBM_OFS_BANK_SEL);
  wire wr_mode  = wr_i && in_bank0 && (addr_i == `UIBM_OFS_MODE_CTL);
  wire wr_ext1  = wr_i && (addr_i == `UIBM_OFS_EXT_CTL1);
  wire wr_fifo  = wr_i && (addr_i == `UIBM_OFS_FIFO_CTL);
  wire wr_cfg   = wr_i && (addr_i == `UIBM_OFS_CFG);
  wire mode_chg = wr_mode && ext_sel && (wdata_i[7:5] != mode_field);
  assign status_read    = rd_i && in_bank0 && (addr_i == `UIBM_OFS_LINK_STAT);
  assign rx_data_read_o = 1'b0;
  // transmit data port write shares offset 0 of bank 0
  assign tx_data_write_o = wr_i && in_bank0 && (addr_i == 4'h0);

  // writes at the status offset are simply dropped
  always @(posedge clock_i or negedge rst_s2) begin
    if (!rst_s2) begin
      bank_selector             <= `UIBM_RST_BANK_SEL;
      link_control              <= 7'h00;
      irq_output_gate           <= 1'b0;
      loop_bit                  <= 1'b0;
      dma_en                    <= 1'b0;
      transmit_deferral                    <= 1'b0;
      interaction_pulse_request <= 1'b0;
      mode_field                <= 3'h0;
      ext_sel                   <= 1'b0;
      fifo_en                   <= 1'b0;
      rx_soft_reset_o           <= 1'b0;
      tx_soft_reset_o           <= 1'b0;
      ir_pulse_o                <= 1'b0;
      pulse_cnt                 <= 8'h00;
      tx_written                <= 1'b0;
    end else begin
      rx_soft_reset_o <= mode_chg || (wr_fifo && wdata_i[1]);
      tx_soft_reset_o <= mode_chg || (wr_fifo && wdata_i[2]);
      if (wr_bank) begin
        bank_selector <= wdata_i;
        if (!wdata_i[`UIBM_BIT_BANK_WINDOW_ENABLE])
          link_control <= wdata_i[6:0];
      end
      if (wr_fifo)
        fifo_en <= wdata_i[0];
      if (wr_cfg)
        ext_sel <= wdata_i[0];
      if (wr_ext1)
        loop_bit <= wdata_i[`UIBM_BIT_LOOP];
      if (wr_mode) begin
        if (ext_sel) begin
          dma_en     <= wdata_i[`UIBM_BIT_DMA_EN];
          transmit_deferral     <= wdata_i[`UIBM_BIT_TRANSMIT_DEFERRAL];
          mode_field <= wdata_i[7:5];
        end else begin
          irq_output_gate <= wdata_i[`UIBM_BIT_IRQ_GATE];
          loop_bit        <= wdata_i[`UIBM_BIT_LOOP];
        end
      end
      // set wins over the self-clear when both land together
      if (wr_mode && ext_sel && wdata_i[`UIBM_BIT_IPULSE])
        interaction_pulse_request <= 1'b1;
      else if (tx_soft_reset_o)
        interaction_pulse_request <= 1'b0;
      else if (frame_mode && tx_frame_end_i && interaction_pulse_request)
        interaction_pulse_request <= 1'b0;
      if (frame_mode && tx_frame_end_i && interaction_pulse_request) begin
        ir_pulse_o <= 1'b1;
        pulse_cnt  <= PULSE_CYC[7:0] - 8'h01;
      end else if (pulse_cnt != 8'h00)
        pulse_cnt <= pulse_cnt - 8'h01;
      else
        ir_pulse_o <= 1'b0;
      // masks the datapath's one-cycle lag after a write, no longer
      tx_written <= tx_data_write_o;
    end
  end

  assign extended_mode_o        = ext_sel;
  assign operating_mode_field_o = mode_field;
  assign loopback_o             = loop_bit;
  assign irq_enable_o           = ext_sel ? 1'b1 : irq_output_gate;
  assign dma_enable_o           = ext_sel && dma_en;
  assign dma_data_route_o       = dma_enable_o;  // ignores bank
  assign fifo_enable_o          = fifo_en || frame_mode ||
                                  (ext_sel && mode_field == `UIBM_MODE_CREM);
  assign transmit_deferral_o    = ext_sel && transmit_deferral && fifo_enable_o;

  // sticky event capture; index 0 overrun, 1 parity/crc, 2 framing/phy, 3 break/size
  wire ev_overrun = rx_char_done_i &&
                    (rx_store_full_i || (frame_mode && status_queue_full_i));
  wire ev_b2 = frame_mode ? (rx_bottom_i && rx_bottom_crc_i)
                          : (rx_bottom_i && rx_bottom_parity_i);
  wire ev_b3 = frame_mode ? (rx_bottom_i && rx_bottom_phy_i)
                          : (rx_bottom_i && rx_bottom_framing_i);
  wire ev_b4 = frame_mode ? (rx_bottom_i && rx_bottom_oversize_i)
                          : (rx_bottom_i && rx_bottom_break_i);
  wire ev_fe = frame_mode && rx_bottom_i && rx_bottom_frame_end_i;

  always @(posedge clock_i or negedge rst_s2) begin
    if (!rst_s2) begin
      sticky            <= 5'h00;
      frame_end_reached <= 1'b0;
    end else begin
      // an event in the read cycle survives the clear
      sticky <= ((status_read || rx_soft_reset_o) ? 5'h00 : sticky) |
                {1'b0, ev_b4, ev_b3, ev_b2, ev_overrun};
      frame_end_reached <= ((status_read || rx_soft_reset_o) ? 1'b0 : frame_end_reached)
                           | ev_fe;
    end
  end

  wire tx_free = tx_store_empty_i && !tx_written;
  wire [7:0] status_image = {
    frame_mode ? frame_end_reached : (ext_sel && rx_err_in_fifo_i),
    tx_free && tx_front_idle_i,
    tx_free,
    sticky[3:0],
    rx_nonempty_i
  };

  always @(posedge clock_i or negedge rst_s2) begin
    if (!rst_s2)
      rdata_o <= 8'h00;
    else if (rd_i) begin
      case (addr_i)
        `UIBM_OFS_BANK_SEL:  rdata_o <= bank_selector;
        `UIBM_OFS_MODE_CTL:  rdata_o <= !in_bank0 ? 8'h00 : ext_sel ?
                               {mode_field, interaction_pulse_request, transmit_deferral, dma_en, 2'b00} :
                               {3'b000, loop_bit, irq_output_gate, 3'b000};
        `UIBM_OFS_LINK_STAT: rdata_o <= in_bank0 ? status_image : 8'h00;
        `UIBM_OFS_LINK_CTL:  rdata_o <= {1'b0, link_control};
        `UIBM_OFS_EXT_CTL1:  rdata_o <= {3'b000, loop_bit, 4'h0};
        `UIBM_OFS_CFG:       rdata_o <= {7'h00, ext_sel};
        default:             rdata_o <= 8'h00;
      endcase
    end else
      rdata_o <= 8'h00;
  end
endmodule

// File: sim/tb.sv
// self-checking bench for the bank, mode and status block
// assumes the transmit stand-in model and the bound port checker
`include "uibm_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] a_mode = `UIBM_OFS_MODE_CTL, a_stat = `UIBM_OFS_LINK_STAT;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic [12:0] rx = 13'h0000;
  logic [7:0]  rdata_o, got;
  logic [2:0]  bank_o, operating_mode_field_o;
  logic        bank_reserved_o, extended_mode_o, loopback_o, irq_enable_o, dma_enable_o;
  logic        transmit_deferral_o, fifo_enable_o, rx_soft_reset_o, tx_soft_reset_o;
  logic        ir_pulse_o, tx_data_write_o, tx_store_empty_i, tx_front_idle_i, tx_frame_end_i;
  int          n_mismatch = 0;
  int          num_checks = 0;
  logic [7:0]  bsel[12] = '{8'h7f, 8'h80, 8'hc2, 8'hc1, 8'he0, 8'he4, 8'he8, 8'hec, 8'hf0,
                            8'hf4, 8'hf8, 8'hdc};
  logic [7:0]  bexp[12] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                            8'h07, 8'h08, 8'h08};
  logic [2:0]  modes[6] = '{3'h2, 3'h4, 3'h6, 3'h0, 3'h3, 3'h5};
  logic [7:0]  tmode[8] = '{8'ha0, 8'ha0, 8'ha0, 8'ha0, 8'ha0, 8'h00, 8'h00, 8'h00};
  logic [12:0] tev[8] = '{13'h0005, 13'h0110, 13'h0210, 13'h0410, 13'h0810, 13'h0030,
                          13'h0050, 13'h0090};
  logic [7:0]  texp[8] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h80, 8'h04, 8'h08, 8'h10};
  uibm_top #(.PULSE_CYC(5)) u_uibm_top (.clock_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .rx_char_done_i(rx[0]), .rx_store_full_i(rx[1]), .status_queue_full_i(rx[2]),
    .rx_nonempty_i(rx[3]), .rx_bottom_i(rx[4]), .rx_bottom_parity_i(rx[5]),
    .rx_bottom_framing_i(rx[6]), .rx_bottom_break_i(rx[7]), .rx_bottom_crc_i(rx[8]),
    .rx_bottom_phy_i(rx[9]), .rx_bottom_oversize_i(rx[10]), .rx_bottom_frame_end_i(rx[11]),
    .rx_err_in_fifo_i(rx[12]), .tx_store_empty_i, .tx_front_idle_i, .tx_frame_end_i, .bank_o,
    .bank_reserved_o, .extended_mode_o, .operating_mode_field_o, .loopback_o, .irq_enable_o,
    .dma_enable_o, .dma_data_route_o(), .transmit_deferral_o, .fifo_enable_o, .rx_soft_reset_o,
    .tx_soft_reset_o, .ir_pulse_o, .tx_data_write_o, .rx_data_read_o());
  uibm_dp_model #(.CHAR_CYC(6)) u_uibm_dp_model (.clock_i, .rst_b_i, .tx_data_write_o,
    .tx_soft_reset_o, .tx_store_empty_i, .tx_front_idle_i, .tx_frame_end_i);
  always #20 clock_i = ~clock_i;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // a dead cycle after each strobe keeps every signal to one assignment per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [3:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    got = rdata_o;
    @(posedge clock_i);
  endtask
  task automatic ev(input logic [12:0] v);
    rx <= v;
    @(posedge clock_i);
    rx <= 13'h0000;
  endtask
  initial begin
    repeat (3000) @(posedge clock_i);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    rd(a_mode);
    chk(got, 8'h00);
    rd(a_stat);
    chk(got, 8'h60);
    rd(4'hf);
    chk(got, 8'h00);
    foreach (bsel[i]) begin
      wr(`UIBM_OFS_BANK_SEL, bsel[i]);
      chk({4'h0, bank_reserved_o, bank_reserved_o ? 3'h0 : bank_o}, bexp[i]);
    end
    wr(`UIBM_OFS_BANK_SEL, 8'h7f);
    rd(`UIBM_OFS_LINK_CTL);
    chk(got, 8'h7f);
    wr(a_mode, 8'hff);
    rd(a_mode);
    chk(got, 8'h18);
    chk(8'({irq_enable_o, loopback_o}), 8'h03);
    wr(`UIBM_OFS_EXT_CTL1, 8'h00);
    rd(a_mode);
    chk(got, 8'h08);
    wr(a_mode, 8'h00);
    chk(8'(irq_enable_o), 8'h00);
    wr(`UIBM_OFS_CFG, 8'h01);
    chk(8'(irq_enable_o), 8'h01);
    wr(a_mode, 8'h0f);
    rd(a_mode);
    chk(got, 8'h0c);
    chk(8'({dma_enable_o, transmit_deferral_o}), 8'h02);
    wr(`UIBM_OFS_FIFO_CTL, 8'h01);
    chk(8'(transmit_deferral_o), 8'h01);
    ev(13'h0003);
    wr(a_mode, 8'h60);
    rd(a_stat);
    chk(got & 8'h02, 8'h00);
    foreach (modes[i]) begin
      wr(a_mode, {modes[i], 5'h00});
      chk(8'(operating_mode_field_o), 8'(modes[i]));
    end
    wr(a_mode, 8'hb0);
    wr(a_mode, 8'ha0);
    rd(a_mode);
    chk(got, 8'hb0);
    wr(4'h0, 8'h5a);
    rd(a_stat);
    chk(got & 8'h60, 8'h20);
    repeat (20) @(posedge clock_i);
    rd(a_mode);
    chk(got, 8'ha0);
    foreach (tev[i]) begin
      wr(a_mode, tmode[i]);
      ev(tev[i]);
      rd(a_stat);
      chk(got & 8'h9e, texp[i]);
      rd(a_stat);
      chk(got & 8'h9e, 8'h00);
    end
    rx <= 13'h1008;
    rd(a_stat);
    chk(got & 8'h81, 8'h81);
    rx <= 13'h0000;
    rd(a_stat);
    chk(got & 8'h81, 8'h00);
    ev(13'h0003);
    rd(a_stat); // status is only ever read
    chk(got & 8'h02, 8'h02);
    give_verdict();
  end
endmodule

// File: sim/uibm_dp_model.sv
// transmit datapath stand-in: holding store and serial front end
// assumes one character per write strobe and a fixed character time
module uibm_dp_model #(parameter int CHAR_CYC = 6) (
  // clock and reset
  input  logic clock_i,
  input  logic rst_b_i,
  // from the block
  input  logic tx_data_write_o,
  input  logic tx_soft_reset_o,
  // status back to the block
  output logic tx_store_empty_i,
  output logic tx_front_idle_i,
  output logic tx_frame_end_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] busy;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy <= 4'h0;
      tx_store_empty_i <= 1'b1;
    end else begin
      tx_store_empty_i <= !tx_data_write_o || tx_soft_reset_o;
      busy <= tx_soft_reset_o ? 4'h0 : tx_data_write_o ? 4'(CHAR_CYC) :
              busy != 4'h0 ? busy - 4'h1 : 4'h0;
    end
  end
  assign tx_front_idle_i = busy == 4'h0;
  // one frame per character: the frame ends as the last bit leaves
  assign tx_frame_end_i = busy == 4'h1;
endmodule

// File: sim/uibm_top_monitor.sv
// port assertions for the bank, mode and status block
// assumes PULSE_CYC is handed down by the bind
module uibm_top_monitor #(parameter int PULSE_CYC = 50) (
  // clock and reset
  input logic       clock_i,
  input logic       rst_b_i,
  // register port
  input logic [3:0] addr_i,
  input logic [7:0] wdata_i,
  input logic       wr_i,
  input logic       rd_i,
  input logic [7:0] rdata_o,
  // datapath status
  input logic       rx_char_done_i,
  input logic       rx_store_full_i,
  input logic       rx_nonempty_i,
  input logic       tx_store_empty_i,
  input logic       tx_front_idle_i,
  // controls
  input logic [2:0] bank_o,
  input logic       bank_reserved_o,
  input logic       extended_mode_o,
  input logic [2:0] operating_mode_field_o,
  input logic       irq_enable_o,
  input logic       rx_soft_reset_o,
  input logic       tx_soft_reset_o,
  input logic       ir_pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic [7:0] hi_cnt;
  wire        bs_wr = wr_i && addr_i == 4'h3;
  wire        st_rd = rd_i && addr_i == 4'h5 && bank_o == 3'h0 && !bank_reserved_o;
  // width counter: a long repetition would be too slow to unroll
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= ir_pulse_o ? hi_cnt + 8'h01 : 8'h00;
  end
  bank_zero_a:
    assert property (bs_wr && !wdata_i[7] |=> bank_o == 3'h0 && !bank_reserved_o)
    else $error("bank not zero");
  bank_one_a:
    assert property (bs_wr && wdata_i[7:6] == 2'b10 |=> bank_o == 3'h1 && !bank_reserved_o)
    else $error("bank not one");
  ext_irq_a:
    assert property (extended_mode_o |-> irq_enable_o) else $error("irq gated in extended mode");
  mode_reset_a:
    assert property ($changed(operating_mode_field_o) |-> rx_soft_reset_o && tx_soft_reset_o)
    else $error("mode change without soft reset");
  pulse_len_a:
    assert property ($fell(ir_pulse_o) |-> hi_cnt == PULSE_CYC[7:0]) else $error("pulse width");
  rx_avail_a:
    assert property (st_rd |=> rdata_o[0] == $past(rx_nonempty_i)) else $error("data avail");
  tx_state_a:
    assert property (st_rd |=> rdata_o[6:5] ==
      {$past(tx_store_empty_i) && $past(tx_front_idle_i), $past(tx_store_empty_i)})
    else $error("tx status bits");
  overrun_a:
    assert property (rx_char_done_i && rx_store_full_i ##1 st_rd && !rx_soft_reset_o
      |=> rdata_o[1]) else $error("overrun lost");
endmodule
bind uibm_top uibm_top_monitor #(.PULSE_CYC(PULSE_CYC)) u_mon (.clock_i, .rst_b_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_char_done_i, .rx_store_full_i, .rx_nonempty_i,
  .tx_store_empty_i, .tx_front_idle_i, .bank_o, .bank_reserved_o, .extended_mode_o,
  .operating_mode_field_o, .irq_enable_o, .rx_soft_reset_o, .tx_soft_reset_o, .ir_pulse_o);
